// *** cssr_top.v ***
// clock source selection and reset sequencing for the measurement processor
// assumes clk is the always-running 125 MHz management clock and nrst the power-up reset
//
// Operation
// - run from rc for first 1024 cycles
// - then switch to external clock when present
// - fall back to rc when external fails
// - record external oscillator failure for status
// - supply low forces reset, rise starts sequence
// - during reset halt core, keep clocking alive
// - reset pin low 1us before reset
// - hold reset until pin high plus 4096
// - release reset, processor fetches from zero
// - sample straps at power-on or reset
// - enable exactly one serial interface
`timescale 1ns/10ps
`include "cssr_regs.vh"

module cssr_top
#(
   parameter STARTUP_CYC = `CSSR_STARTUP_CYC,
   parameter RST_TIMER_CYC = `CSSR_RST_TIMER_CYC,
   parameter EXT_TIMEOUT_CYC = `CSSR_EXT_TIMEOUT_CYC
)
(
   // clock and power-up reset
   input wire clk,
   input wire nrst,
   // supply monitor and reset pin
   input wire supply_ok,
   input wire reset_pin_n,
   // external oscillator activity, sampled
   input wire ext_clk_in,
   // strap pins
   input wire interface_group_select,
   input wire serial_link_select,
   input wire addr_strap0,
   input wire addr_strap1,
   // failure flag clear from the processor
   input wire osc_fail_clr,
   // clock gating controls and failure flag
   output wire rc_clk_en,
   output wire ext_clk_en,
   output wire clk_sel_ext,
   output wire osc_fail,
   // core reset and boot
   output wire core_rst_n,
   output wire [23:0] boot_addr,
   output wire boot_start,
   // serial interface selection
   output wire [2:0] if_enable,
   output wire [1:0] dev_addr
);

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   // synchronised pins
   wire supply_ok_s;
   wire reset_pin_s;
   wire ext_clk_s;
   wire grp_s;
   wire link_s;
   wire a0_s;
   wire a1_s;

   cssr_sync #(.RST_VAL(1'b0)) u_sync_sup (.clk(clk), .nrst(nrst), .din(supply_ok),
      .dout(supply_ok_s));
   cssr_sync #(.RST_VAL(1'b1)) u_sync_rst (.clk(clk), .nrst(nrst), .din(reset_pin_n),
      .dout(reset_pin_s));
   cssr_sync #(.RST_VAL(1'b0)) u_sync_ext (.clk(clk), .nrst(nrst), .din(ext_clk_in),
      .dout(ext_clk_s));
   cssr_sync #(.RST_VAL(1'b0)) u_sync_grp (.clk(clk), .nrst(nrst),
      .din(interface_group_select), .dout(grp_s));
   cssr_sync #(.RST_VAL(1'b0)) u_sync_lnk (.clk(clk), .nrst(nrst),
      .din(serial_link_select), .dout(link_s));
   cssr_sync #(.RST_VAL(1'b0)) u_sync_a0 (.clk(clk), .nrst(nrst), .din(addr_strap0), .dout(a0_s));
   cssr_sync #(.RST_VAL(1'b0)) u_sync_a1 (.clk(clk), .nrst(nrst), .din(addr_strap1), .dout(a1_s));

   // ----------------------------------------------------------------
   // reset pin filter
   // ----------------------------------------------------------------
   // consecutive low cycles on the pin
   reg [7:0] low_cnt_q;
   // filtered pin reset request
   reg pin_rst_q;

   // a glitch shorter than the filter restarts the count and is dropped
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         low_cnt_q <= 8'h00;
         pin_rst_q <= 1'b0;
      end
      else if (reset_pin_s)
      begin
         // pin high, reset request ends
         low_cnt_q <= 8'h00;
         pin_rst_q <= 1'b0;
      end
      else if (low_cnt_q == (`CSSR_FILTER_CYC - 1))
         pin_rst_q <= 1'b1;
      else
         low_cnt_q <= low_cnt_q + 8'h01;
   end

   // ----------------------------------------------------------------
   // reset sequencer
   // ----------------------------------------------------------------
   // any active reset source
   wire rst_src;
   // post-release timer
   reg [12:0] rst_tmr_q;
   // core held in reset
   reg core_rst_q;
   // one-cycle boot pulse
   reg boot_q;

   assign rst_src = pin_rst_q | ~supply_ok_s;

   // the timer restarts whenever a source is active again
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_tmr_q <= 13'h0000;
         core_rst_q <= 1'b1;
         boot_q <= 1'b0;
      end
      else if (rst_src)
      begin
         rst_tmr_q <= 13'h0000;
         core_rst_q <= 1'b1;
         boot_q <= 1'b0;
      end
      // wait full timer after pin high
      else if (core_rst_q && (rst_tmr_q == RST_TIMER_CYC[12:0] - 13'h0001))
      begin
         core_rst_q <= 1'b0;
         boot_q <= 1'b1;
      end
      else
      begin
         boot_q <= 1'b0;
         if (core_rst_q)
            rst_tmr_q <= rst_tmr_q + 13'h0001;
      end
   end

   assign core_rst_n = ~core_rst_q;
   assign boot_start = boot_q;
   assign boot_addr = `CSSR_BOOT_ADDR;

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   // captured strap values
   reg grp_q;
   reg link_q;
   reg [1:0] addr_q;

   // track straps while in reset, freeze on release
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         grp_q <= 1'b0;
         link_q <= 1'b0;
         addr_q <= 2'h0;
      end
      else if (core_rst_q)
      begin
         grp_q <= grp_s;
         link_q <= link_s;
         addr_q <= {a1_s, a0_s};
      end
   end

   assign if_enable[`CSSR_IF_SPI] = ~grp_q;
   assign if_enable[`CSSR_IF_I2C] = grp_q & link_q;
   assign if_enable[`CSSR_IF_UART] = grp_q & ~link_q;
   assign dev_addr = addr_q;

   // ----------------------------------------------------------------
   // external clock watchdog
   // ----------------------------------------------------------------
   // delayed copy for edge detect, reads the second stage only
   reg ext_dly_q;
   // cycles since last external edge
   reg [7:0] ext_idle_q;
   // external clock seen recently
   reg ext_ok_q;
   wire ext_edge;

   assign ext_edge = ext_clk_s ^ ext_dly_q;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_dly_q <= 1'b0;
         ext_idle_q <= 8'h00;
         ext_ok_q <= 1'b0;
      end
      else
      begin
         ext_dly_q <= ext_clk_s;
         if (ext_edge)
         begin
            ext_idle_q <= 8'h00;
            ext_ok_q <= 1'b1;
         end
         else if (ext_idle_q == EXT_TIMEOUT_CYC[7:0] - 8'h01)
            ext_ok_q <= 1'b0;
         else
            ext_idle_q <= ext_idle_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // clock select state machine
   // ----------------------------------------------------------------
   // state and start-up counter
   reg [2:0] st_q;
   reg [10:0] start_cnt_q;
   // sticky failure flag
   reg fail_q;
   // previous reset source level, to restart the start-up phase
   reg rst_src_q;

   // break-before-make: both gates off for one cycle on every change
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= `CSSR_ST_START;
         start_cnt_q <= 11'h000;
         fail_q <= 1'b0;
         rst_src_q <= 1'b0;
      end
      else
      begin
         rst_src_q <= rst_src;
         if (st_q == `CSSR_ST_EXT && !ext_ok_q)
            fail_q <= 1'b1;
         else if (osc_fail_clr)
            fail_q <= 1'b0;
         if (rst_src && !rst_src_q)
         begin
            // a new reset restarts the rc phase
            st_q <= (st_q == `CSSR_ST_EXT) ? `CSSR_ST_TO_RC : `CSSR_ST_START;
            start_cnt_q <= 11'h000;
         end
         else
            case (st_q)
               `CSSR_ST_START:
                  if (start_cnt_q == STARTUP_CYC[10:0] - 11'h001)
                     st_q <= `CSSR_ST_RC;
                  else
                     start_cnt_q <= start_cnt_q + 11'h001;
               `CSSR_ST_RC:
                  if (ext_ok_q)
                     st_q <= `CSSR_ST_TO_EXT;
               `CSSR_ST_TO_EXT:
                  st_q <= ext_ok_q ? `CSSR_ST_EXT : `CSSR_ST_TO_RC;
               `CSSR_ST_EXT:
                  if (!ext_ok_q)
                     st_q <= `CSSR_ST_TO_RC;
               `CSSR_ST_TO_RC:
                  st_q <= (start_cnt_q == 11'h000) ? `CSSR_ST_START : `CSSR_ST_RC;
               default:
                  st_q <= `CSSR_ST_START;
            endcase
      end
   end

   // gate enables, never both high
   assign rc_clk_en = (st_q == `CSSR_ST_START) | (st_q == `CSSR_ST_RC);
   assign ext_clk_en = (st_q == `CSSR_ST_EXT);
   assign clk_sel_ext = (st_q == `CSSR_ST_EXT) | (st_q == `CSSR_ST_TO_EXT);
   assign osc_fail = fail_q;

endmodule // cssr_top

// *** cssr_regs.vh ***
// timing counts, state codes and boot address for the clock-select and reset sequencer
// assumes a single 125 MHz system clock; included by bare name
`ifndef CSSR_REGS_VH
`define CSSR_REGS_VH

// ----------------------------------------------------------------
// clock rate
// ----------------------------------------------------------------
`define CSSR_CLK_MHZ 125

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
// cycles on rc oscillator after any reset
`define CSSR_STARTUP_CYC 1024
// least low time on the reset pin, in ns
`define CSSR_FILTER_NS 1000
// least time rounded up to whole cycles
`define CSSR_FILTER_CYC ((`CSSR_FILTER_NS * `CSSR_CLK_MHZ + 999) / 1000)
// reset timer after the pin returns high
`define CSSR_RST_TIMER_CYC 4096
// cycles without an external edge before it counts as lost
`define CSSR_EXT_TIMEOUT_CYC 16

// ----------------------------------------------------------------
// clock select states
// ----------------------------------------------------------------
`define CSSR_ST_START 3'h0
`define CSSR_ST_RC 3'h1
`define CSSR_ST_TO_EXT 3'h2
`define CSSR_ST_EXT 3'h3
`define CSSR_ST_TO_RC 3'h4

// ----------------------------------------------------------------
// boot address and interface enable bits
// ----------------------------------------------------------------
`define CSSR_BOOT_ADDR 24'h000000
`define CSSR_IF_SPI 2
`define CSSR_IF_I2C 1
`define CSSR_IF_UART 0

`endif

// *** cssr_sync.v ***
// two-flop synchroniser for one level from outside the clock domain
// assumes clk is the system clock and nrst the async active-low reset
`timescale 1ns/10ps

module cssr_sync
#(
   parameter RST_VAL = 1'b0
)
(
   // clock and reset
   input wire clk,
   input wire nrst,
   // asynchronous level in
   input wire din,
   // synchronised level out
   output wire dout
);

   // first stage, read only by the second
   reg meta_q;
   // second stage
   reg sync_q;

   // ----------------------------------------------------------------
   // two stages
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule // cssr_sync

// *** cssr_top_checker.sv ***
// checker for the clock-select and reset sequencer ports
// assumes it is bound into cssr_top with the same counts
`timescale 1ns/10ps

module cssr_top_checker
#(
   parameter STARTUP_CYC = 1024,
   parameter RST_TIMER_CYC = 4096,
   parameter EXT_TIMEOUT_CYC = 16
)
(
   // clock and reset
   input wire clk,
   input wire nrst,
   // inputs
   input wire supply_ok,
   input wire reset_pin_n,
   input wire osc_fail_clr,
   // clock gates and flag
   input wire rc_clk_en,
   input wire ext_clk_en,
   input wire clk_sel_ext,
   input wire osc_fail,
   // core and straps
   input wire core_rst_n,
   input wire [23:0] boot_addr,
   input wire boot_start,
   input wire [2:0] if_enable,
   input wire [1:0] dev_addr
);
   // run lengths: pin high, pin low, since reset
   logic [13:0] hi_q, lo_q, sc_q;
   // supply high run, saturates at 7
   logic [2:0] ok_q;

   // saturating counters, so long runs never wrap
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hi_q <= 14'h0;
         lo_q <= 14'h0;
         sc_q <= 14'h0;
         ok_q <= 3'h0;
      end
      else
      begin
         hi_q <= (reset_pin_n && supply_ok) ? hi_q + (hi_q != 14'h3FFF) : 14'h0;
         lo_q <= !reset_pin_n ? lo_q + (lo_q != 14'h3FFF) : 14'h0;
         sc_q <= sc_q + (sc_q != 14'h3FFF);
         ok_q <= supply_ok ? ok_q + (ok_q != 3'h7) : 3'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_gates_excl: assert property (!(rc_clk_en && ext_clk_en))
      else $error("both clock gates open");
   a_dead_cycle: assert property (($rose(ext_clk_en) || $rose(rc_clk_en))
      |-> $past(!rc_clk_en && !ext_clk_en)) else $error("gate switched with no gap");
   a_startup_rc: assert property (sc_q < STARTUP_CYC |-> rc_clk_en && !clk_sel_ext)
      else $error("left rc clock early");
   a_fail_back: assert property ($rose(osc_fail) |-> ##[0:2] rc_clk_en)
      else $error("no return to rc clock");
   a_fail_clear: assert property (osc_fail_clr && !clk_sel_ext |=> !osc_fail)
      else $error("failure flag not cleared");
   a_pin_filter: assert property ($fell(core_rst_n) && ok_q == 3'h7 |-> lo_q >= 125)
      else $error("short pin pulse reset the core");
   a_hold_timer: assert property ($rose(core_rst_n) |-> hi_q >= RST_TIMER_CYC
      && hi_q <= RST_TIMER_CYC + 5) else $error("reset timer length wrong");
   a_boot_pulse: assert property (boot_start == $rose(core_rst_n))
      else $error("boot pulse off release");
   a_boot_zero: assert property (boot_start |-> boot_addr == 24'h0)
      else $error("boot address not zero");
   a_if_onehot: assert property ($onehot(if_enable))
      else $error("interface enable not one-hot");
   a_straps_frozen: assert property (core_rst_n && $past(core_rst_n)
      |-> $stable(if_enable) && $stable(dev_addr)) else $error("straps moved in run");

   c_ext: cover property ($rose(ext_clk_en));
   c_fail: cover property ($rose(osc_fail));
   c_boot: cover property (boot_start);
endmodule // cssr_top_checker

bind cssr_top cssr_top_checker #(.STARTUP_CYC(STARTUP_CYC), .RST_TIMER_CYC(RST_TIMER_CYC),
   .EXT_TIMEOUT_CYC(EXT_TIMEOUT_CYC)) u_chk (.clk(clk), .nrst(nrst),
   .supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .osc_fail_clr(osc_fail_clr),
   .rc_clk_en(rc_clk_en), .ext_clk_en(ext_clk_en), .clk_sel_ext(clk_sel_ext),
   .osc_fail(osc_fail), .core_rst_n(core_rst_n), .boot_addr(boot_addr),
   .boot_start(boot_start), .if_enable(if_enable), .dev_addr(dev_addr));

// *** cssr_far.sv ***
// far-side model: external oscillator and reset pin driver
// assumes the bench commands osc_on and pin_low at clk edges
`timescale 1ns/10ps

module cssr_far
(
   // clock
   input wire clk,
   // commands
   input wire osc_on,
   input wire pin_low,
   // pins
   output logic ext_clk_in,
   output wire reset_pin_n
);
   // a dead oscillator stands still, which the block must notice
   initial ext_clk_in = 1'b0;
   always @(posedge clk)
   begin
      if (osc_on)
         ext_clk_in <= !ext_clk_in;
   end
   // held low as long as commanded, pulled up when released
   assign reset_pin_n = !pin_low;
endmodule // cssr_far

// *** cssr_top_tb.sv ***
// self-checking bench for the clock-select and reset sequencer
// assumes the far-side model and the bound checker
`timescale 1ns/10ps

module cssr_top_tb;
   logic clk, nrst, supply_ok, grp_sel, link_sel, as1, as0, fclr, osc_on, pin_low;
   wire ext_clk_in, reset_pin_n, rc_clk_en, ext_clk_en, clk_sel_ext, osc_fail;
   wire core_rst_n, boot_start;
   wire [23:0] boot_addr;
   wire [2:0] if_enable;
   wire [1:0] dev_addr;
   int mismatches = 0, tests_run = 0, cyc_q = 0, i;
   logic seen_low;

   // short counts keep the run brief
   cssr_top #(.STARTUP_CYC(8), .RST_TIMER_CYC(16), .EXT_TIMEOUT_CYC(4)) uut (.clk(clk),
      .nrst(nrst), .supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .ext_clk_in(ext_clk_in),
      .interface_group_select(grp_sel), .serial_link_select(link_sel), .addr_strap0(as0),
      .addr_strap1(as1), .osc_fail_clr(fclr), .rc_clk_en(rc_clk_en), .ext_clk_en(ext_clk_en),
      .clk_sel_ext(clk_sel_ext), .osc_fail(osc_fail), .core_rst_n(core_rst_n),
      .boot_addr(boot_addr), .boot_start(boot_start), .if_enable(if_enable), .dev_addr(dev_addr));
   cssr_far u_far (.clk(clk), .osc_on(osc_on), .pin_low(pin_low), .ext_clk_in(ext_clk_in),
      .reset_pin_n(reset_pin_n));

   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end

   // hang guard
   always @(posedge clk)
   begin
      cyc_q++;
      if (cyc_q == 20000)
      begin
         mismatches++;
         $display("ERROR %0t: run timed out", $time);
         test_done;
      end
   end

   task chk(input logic [23:0] seen, input logic [23:0] exp);
   begin
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task test_done;
   begin
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // settle one nanosecond past the edges so outputs are read stable
   task tick(input int n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask

   task do_nrst;
   begin
      @(posedge clk) nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(1);
   end
   endtask

   task pin_pulse(input int n);
   begin
      @(posedge clk) pin_low <= 1'b1;
      repeat (n) @(posedge clk);
      pin_low <= 1'b0;
   end
   endtask

   // wait for release, then judge the timer and boot pulse
   task rise;
   begin
      for (i = 0; i < 60 && core_rst_n !== 1'b1; i++)
         tick(1);
      chk(i >= 15 && i <= 24, 1);
      chk(boot_start, 1);
      chk(boot_addr, 24'h0);
      tick(1);
      chk(boot_start, 0);
   end
   endtask

   // each interface and address strap value, then straps moved in run
   task t_straps;
      int k;
      logic [2:0] exp;
   begin
      for (k = 0; k < 4; k++)
      begin
         @(posedge clk) {grp_sel, link_sel, as1, as0} <= {k[1], k[0], k[0], k[1]};
         pin_pulse(130);
         rise;
         exp = k[1] ? (k[0] ? 3'b010 : 3'b001) : 3'b100;
         chk(if_enable, exp);
         chk(dev_addr, {k[0], k[1]});
         @(posedge clk) {grp_sel, link_sel, as1, as0} <= ~{k[1], k[0], k[0], k[1]};
         tick(4);
         chk(if_enable, exp);
         chk(dev_addr, {k[0], k[1]});
      end
   end
   endtask

   // short pulse ignored; long pulse halts core but not clocking
   task t_filter;
   begin
      seen_low = 1'b0;
      @(posedge clk) pin_low <= 1'b1;
      for (i = 0; i < 100; i++)
      begin
         tick(1);
         seen_low = seen_low | !core_rst_n;
      end
      @(posedge clk) pin_low <= 1'b0;
      tick(4);
      chk(seen_low, 0);
      @(posedge clk) pin_low <= 1'b1;
      tick(200);
      chk(core_rst_n, 0);
      chk(ext_clk_en, 1);
      @(posedge clk) pin_low <= 1'b0;
      rise;
   end
   endtask

   task t_supply;
   begin
      @(posedge clk) supply_ok <= 1'b0;
      repeat (5) @(posedge clk);
      supply_ok <= 1'b1;
      tick(1);
      chk(core_rst_n, 0);
      rise;
   end
   endtask

   task t_clock;
   begin
      do_nrst;
      for (i = 0; i < 6; i++)
      begin
         chk(ext_clk_en, 0);
         chk(rc_clk_en, 1);
         chk(clk_sel_ext, 0);
         tick(1);
      end
      for (i = 0; i < 40 && ext_clk_en !== 1'b1; i++)
         tick(1);
      chk(ext_clk_en, 1);
      chk(clk_sel_ext, 1);
      @(posedge clk) osc_on <= 1'b0;
      for (i = 0; i < 30 && osc_fail !== 1'b1; i++)
         tick(1);
      chk(osc_fail, 1);
      tick(3);
      chk(rc_clk_en, 1);
      chk(clk_sel_ext, 0);
      tick(20);
      chk(osc_fail, 1);
      @(posedge clk) fclr <= 1'b1;
      @(posedge clk) fclr <= 1'b0;
      tick(1);
      chk(osc_fail, 0);
      do_nrst;
      tick(40);
      chk(ext_clk_en, 0);
      chk(osc_fail, 0);
   end
   endtask

   // order: nrst, supply, group, link, addr1, addr0, clear, osc, pin
   // reset held and supply good from time zero, oscillator running
   initial
   begin
      {nrst, supply_ok, grp_sel, link_sel, as1, as0, fclr, osc_on, pin_low} = 9'h082;
      do_nrst;
      rise;
      t_straps;
      t_filter;
      t_supply;
      t_clock;
      test_done;
   end
endmodule // cssr_top_tb
